//--- src/exposure_readout_sequencer.sv
// exposure control and frame readout sequencer
`timescale 1ns/1ps
`default_nettype none
module exposure_readout_sequencer #(
    parameter int ROWS = exposure_readout_pkg::ROWS_DEF,
    parameter int KERNELS = exposure_readout_pkg::KERNELS_DEF,
    parameter int TIMER_W = exposure_readout_pkg::TIMER_W_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic captureEnable,
    input wire logic masterTiming,
    input wire logic triggeredShutter,
    input wire logic subsampleEnable,
    input wire logic cycleGranularity,
    input wire logic syncToRowOverhead,
    input wire logic [exposure_readout_pkg::MULT_W-1:0] cycleMultiplier,
    input wire logic reverseX,
    input wire logic reverseY,
    input wire logic [exposure_readout_pkg::WIN_W-1:0] windowCount,
    input wire logic [TIMER_W-1:0] resetLength,
    input wire logic [TIMER_W-1:0] integrationTime,
    input wire logic [TIMER_W-1:0] rowOverheadCycles,
    input wire logic [TIMER_W-1:0] frameTransferCycles,
    input wire logic [3:0][exposure_readout_pkg::ROW_W-1:0] windowYStart,
    input wire logic [3:0][exposure_readout_pkg::ROW_W-1:0] windowYEnd,
    input wire logic [3:0][exposure_readout_pkg::KER_W-1:0] windowXStart,
    input wire logic [3:0][exposure_readout_pkg::KER_W-1:0] windowXKernels,
    input wire logic integrationPinPrimary,
    output logic pixelReset,
    output logic integrating,
    output logic imageSample,
    output logic frameTransfer,
    output logic rowOverhead,
    output logic readoutBusy,
    output logic kernelValid,
    output logic [exposure_readout_pkg::ROW_W-1:0] rowAddress,
    output logic [exposure_readout_pkg::ROW_W-1:0] outputRow,
    output logic [exposure_readout_pkg::KER_W-1:0] kernelAddress,
    output logic [exposure_readout_pkg::WIN_W-1:0] windowIndex
);
    localparam int RW = exposure_readout_pkg::ROW_W;
    localparam int KW = exposure_readout_pkg::KER_W;
    localparam int WW = exposure_readout_pkg::WIN_W;
    localparam int CW = TIMER_W + 1;
    localparam logic [RW-1:0] ROW_LAST = RW'(ROWS - 1);
    localparam logic [KW-1:0] KER_LAST = KW'(KERNELS - 1);
    localparam logic [CW-1:0] LINE_KERNELS = CW'(KERNELS);

    if (ROWS < 1 || ROWS > (1 << RW) || KERNELS < 1 || KERNELS > (1 << KW)
        || TIMER_W < 2 || TIMER_W > 30) begin : gParamCheck
        $error("unsupported array size or timer width");
    end

    // ****
    // functions
    // ****
    function automatic logic countDone(input logic [CW-1:0] count,
                                       input logic [CW-1:0] limit);
        return (CW'(count + CW'(1)) >= limit);
    endfunction

    function automatic logic [RW-1:0] physRow(input logic [RW-1:0] row,
                                              input logic rev);
        return rev ? RW'(ROW_LAST - row) : row;
    endfunction

    function automatic logic [KW-1:0] physKernel(input logic [KW-1:0] base,
                                                 input logic [KW-1:0] idx,
                                                 input logic sub,
                                                 input logic rev);
        logic [KW-1:0] k;
        k = KW'(base + (sub ? KW'(idx << 1) : idx));
        return rev ? KW'(KER_LAST - k) : k;
    endfunction

    // ****
    // pin synchronisation and shared signals
    // ****
    logic pinRise, pinFall;
    logic timerStart, timerDone;
    logic [TIMER_W-1:0] timerValue;
    logic lineTick, rotWindow, idleRot;
    logic sampleNow;
    logic [CW-1:0] lcnt_q;
    exposure_readout_pkg::expState_t ex_q, ex_d;
    exposure_readout_pkg::rdState_t rd_q;

    pin_edge_sync uPinSync (
        .clk(clk),
        .reset_n(reset_n),
        .pin(integrationPinPrimary),
        .level(),
        .rise(pinRise),
        .fall(pinFall)
    );

    granular_timer #(.W(TIMER_W)) uExpTimer (
        .clk(clk),
        .reset_n(reset_n),
        .start(timerStart),
        .value(timerValue),
        .lineMode(!cycleGranularity),
        .lineTick(lineTick),
        .multiplier(cycleMultiplier),
        .done(timerDone)
    );

    // ****
    // line timing while readout is idle
    // ****
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lcnt_q <= '0;
        end else if (rd_q != exposure_readout_pkg::RD_IDLE) begin
            lcnt_q <= '0;
        end else if (countDone(lcnt_q, CW'(rowOverheadCycles) + LINE_KERNELS)) begin
            lcnt_q <= '0;
        end else begin
            lcnt_q <= CW'(lcnt_q + CW'(1));
        end
    end

    assign idleRot = (rd_q == exposure_readout_pkg::RD_IDLE)
                     && (lcnt_q < CW'(rowOverheadCycles));
    assign rotWindow = (rd_q == exposure_readout_pkg::RD_ROT) || idleRot;

    // ****
    // exposure control
    // ****
    logic evtRaw, gated, applyOk, apply, pend_q;

    always_comb begin
        evtRaw = 1'b0;
        gated = 1'b0;
        unique case (ex_q)
            exposure_readout_pkg::EX_IDLE: evtRaw = captureEnable;
            exposure_readout_pkg::EX_ARMED: begin
                evtRaw = pinRise;
                gated = 1'b1;
            end
            exposure_readout_pkg::EX_RESET: begin
                evtRaw = timerDone;
                gated = 1'b1;
            end
            exposure_readout_pkg::EX_INTEG: begin
                // master ignores the falling edge entirely
                evtRaw = masterTiming ? timerDone : pinFall;
                gated = 1'b1;
            end
            exposure_readout_pkg::EX_HOLD: evtRaw = !readoutBusy;
        endcase
    end

    // integration changes land in row overhead unless cycle mode runs free
    assign applyOk = cycleGranularity ? (!syncToRowOverhead || rotWindow)
                                      : rotWindow;
    assign apply = (evtRaw || pend_q) && (!gated || applyOk);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= gated && (evtRaw || pend_q) && !apply;
        end
    end

    always_comb begin
        ex_d = ex_q;
        timerStart = 1'b0;
        timerValue = integrationTime;
        sampleNow = 1'b0;
        if (apply) begin
            unique case (ex_q)
                exposure_readout_pkg::EX_IDLE: begin
                    if (masterTiming && !triggeredShutter) begin
                        ex_d = exposure_readout_pkg::EX_RESET;
                        timerStart = 1'b1;
                        timerValue = resetLength;
                    end else begin
                        ex_d = exposure_readout_pkg::EX_ARMED;
                    end
                end
                exposure_readout_pkg::EX_ARMED: begin
                    ex_d = exposure_readout_pkg::EX_INTEG;
                    timerStart = masterTiming;
                end
                exposure_readout_pkg::EX_RESET: begin
                    ex_d = exposure_readout_pkg::EX_INTEG;
                    timerStart = 1'b1;
                end
                exposure_readout_pkg::EX_INTEG: begin
                    sampleNow = 1'b1;
                    if (triggeredShutter) begin
                        ex_d = exposure_readout_pkg::EX_HOLD;
                    end else if (!captureEnable) begin
                        ex_d = exposure_readout_pkg::EX_IDLE;
                    end else if (masterTiming) begin
                        ex_d = exposure_readout_pkg::EX_RESET;
                        timerStart = 1'b1;
                        timerValue = resetLength;
                    end else begin
                        ex_d = exposure_readout_pkg::EX_ARMED;
                    end
                end
                exposure_readout_pkg::EX_HOLD: begin
                    ex_d = captureEnable ? exposure_readout_pkg::EX_ARMED
                                         : exposure_readout_pkg::EX_IDLE;
                end
            endcase
        end else if (!captureEnable && (ex_q == exposure_readout_pkg::EX_ARMED
                                        || ex_q == exposure_readout_pkg::EX_RESET)) begin
            ex_d = exposure_readout_pkg::EX_IDLE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ex_q <= exposure_readout_pkg::EX_IDLE;
            imageSample <= 1'b0;
        end else begin
            ex_q <= ex_d;
            imageSample <= sampleNow;
        end
    end

    assign integrating = (ex_q == exposure_readout_pkg::EX_INTEG);
    assign pixelReset = !integrating;

    // ****
    // readout sequencing
    // ****
    logic [CW-1:0] cnt_q;
    logic [WW-1:0] win_q;
    logic [RW-1:0] row_q;
    logic [KW-1:0] ker_q;
    logic rowEnd;

    assign rowEnd = (rd_q == exposure_readout_pkg::RD_KERN)
                    && (KW'(ker_q + KW'(1)) >= windowXKernels[win_q]);
    assign lineTick = ((rd_q == exposure_readout_pkg::RD_ROT) && (cnt_q == '0))
                      || ((rd_q == exposure_readout_pkg::RD_IDLE) && (lcnt_q == '0));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_q <= exposure_readout_pkg::RD_IDLE;
            cnt_q <= '0;
            win_q <= '0;
            row_q <= '0;
            ker_q <= '0;
            outputRow <= '0;
        end else if (sampleNow) begin
            // a new sample restarts readout whatever its progress
            rd_q <= exposure_readout_pkg::RD_FOT;
            cnt_q <= '0;
            win_q <= '0;
            outputRow <= '0;
        end else begin
            unique case (rd_q)
                exposure_readout_pkg::RD_IDLE: cnt_q <= '0;
                exposure_readout_pkg::RD_FOT: begin
                    cnt_q <= CW'(cnt_q + CW'(1));
                    if (countDone(cnt_q, CW'(frameTransferCycles))) begin
                        rd_q <= exposure_readout_pkg::RD_ROT;
                        cnt_q <= '0;
                        row_q <= windowYStart[0];
                    end
                end
                exposure_readout_pkg::RD_ROT: begin
                    cnt_q <= CW'(cnt_q + CW'(1));
                    if (countDone(cnt_q, CW'(rowOverheadCycles))) begin
                        rd_q <= exposure_readout_pkg::RD_KERN;
                        cnt_q <= '0;
                        ker_q <= '0;
                    end
                end
                exposure_readout_pkg::RD_KERN: begin
                    ker_q <= KW'(ker_q + KW'(1));
                    if (rowEnd) begin
                        outputRow <= RW'(outputRow + RW'(1));
                        rd_q <= exposure_readout_pkg::RD_ROT;
                        if (row_q != windowYEnd[win_q]) begin
                            row_q <= RW'(row_q + RW'(1));
                        end else if (win_q != windowCount) begin
                            win_q <= WW'(win_q + WW'(1));
                            row_q <= windowYStart[WW'(win_q + WW'(1))];
                        end else begin
                            rd_q <= exposure_readout_pkg::RD_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ****
    // registered address outputs
    // ****
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rowAddress <= '0;
            kernelAddress <= '0;
            kernelValid <= 1'b0;
            windowIndex <= '0;
        end else begin
            rowAddress <= physRow(row_q, reverseY);
            kernelValid <= (rd_q == exposure_readout_pkg::RD_KERN);
            windowIndex <= win_q;
            if (rd_q == exposure_readout_pkg::RD_KERN) begin
                kernelAddress <= physKernel(windowXStart[win_q], ker_q,
                                            subsampleEnable, reverseX);
            end
        end
    end

    assign frameTransfer = (rd_q == exposure_readout_pkg::RD_FOT);
    assign rowOverhead = (rd_q == exposure_readout_pkg::RD_ROT);
    assign readoutBusy = (rd_q != exposure_readout_pkg::RD_IDLE);
endmodule
`default_nettype wire

//--- common/exposure_readout_pkg.sv
// constants and state types shared by the exposure and readout sequencer
// Behaviour
// - every frame readout opens with frame transfer
// - row overhead first, then one kernel per clock
// - pipelined master makes all timing; slave follows pin
// - pipelined integrates during previous frame readout
// - granularity bit picks lines or scaled cycles
// - line mode changes only during row overhead
// - cycle mode immediate unless synced to overhead
// - exposure timers selectable, readout timers cycles
// - pipelined slave: rise leaves reset, fall samples
// - triggered reads one image per request
// - triggered master: rise starts, timer ends
// - triggered holds array reset during readout
// - triggered slave: fall starts frame transfer
// - window column start is kernel units
// - window width counts kernels, doubled subsampled
// - reverse X and Y flip physical addressing
// - windows read strictly in order, from zero up to the window count
// - one frame transfer, then all counted windows
// - shutter bit selects pipelined or triggered
// - timing bit selects master or slave
// - window count field selects one to four
package exposure_readout_pkg;
    localparam int ROWS_DEF = 1024;
    localparam int KERNELS_DEF = 54;
    localparam int PIX_PER_KERNEL = 24;
    localparam int PIX_PER_EDGE = 12;
    localparam int SUB_COLS = 48;
    localparam int TIMER_W_DEF = 16;
    localparam int MULT_W = 4;
    localparam int PRE_W = 16;
    localparam int ROW_W = 10;
    localparam int KER_W = 6;
    localparam int WIN_W = 2;
    localparam int WIN_MAX = 4;
    localparam int CLK_PERIOD_NS = 8;
    localparam logic RESET_PIXEL_RESET = 1'b1;

    typedef enum logic [4:0] {
        EX_IDLE = 5'b00001,
        EX_ARMED = 5'b00010,
        EX_RESET = 5'b00100,
        EX_INTEG = 5'b01000,
        EX_HOLD = 5'b10000
    } expState_t;

    typedef enum logic [3:0] {
        RD_IDLE = 4'b0001,
        RD_FOT = 4'b0010,
        RD_ROT = 4'b0100,
        RD_KERN = 4'b1000
    } rdState_t;
endpackage

//--- src/pin_edge_sync.sv
// three-stage pin synchroniser with edge pulses
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_q, s2_q, s3_q;
    logic level_q, rise_q, fall_q;

    // s1 feeds s2 only; a change counts once s2 and s3 agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            rise_q <= (s2_q == s3_q) && s3_q && !level_q;
            fall_q <= (s2_q == s3_q) && !s3_q && level_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

    assign level = level_q;
    assign rise = rise_q;
    assign fall = fall_q;
endmodule
`default_nettype wire

//--- src/granular_timer.sv
// exposure timer counting lines or scaled clock cycles
`timescale 1ns/1ps
`default_nettype none
module granular_timer #(
    parameter int W = exposure_readout_pkg::TIMER_W_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [W-1:0] value,
    input wire logic lineMode,
    input wire logic lineTick,
    input wire logic [exposure_readout_pkg::MULT_W-1:0] multiplier,
    output logic done
);
    localparam int PW = exposure_readout_pkg::PRE_W;
    logic [W-1:0] cnt_q;
    logic [PW-1:0] pre_q;
    logic active_q, done_q;
    logic [PW-1:0] preLimit;
    logic tick;

    // cycle mode: one count every 2**multiplier cycles
    assign preLimit = PW'((PW'(1) << multiplier) - PW'(1));
    assign tick = lineMode ? lineTick : (pre_q == preLimit);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
            pre_q <= '0;
            active_q <= 1'b0;
            done_q <= 1'b0;
        end else if (start) begin
            cnt_q <= value;
            pre_q <= '0;
            active_q <= (value != '0);
            done_q <= (value == '0);
        end else if (active_q) begin
            if (tick) begin
                pre_q <= '0;
                cnt_q <= cnt_q - W'(1);
                if (cnt_q == W'(1)) begin
                    active_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end else begin
                pre_q <= pre_q + PW'(1);
            end
        end
    end

    assign done = done_q;
endmodule
`default_nettype wire

//--- tb/controller_model.sv
// camera controller model driving the primary integration pin
`timescale 1ns/1ps
`default_nettype none
module controller_model (
    input wire logic clk,
    input wire logic rowOverhead,
    input wire logic readoutBusy,
    output logic pin
);
    // ****
    // pin requests
    // ****
    initial pin = 1'b0;
    task automatic edgeAtRot(input logic v);
        while (readoutBusy === 1'b1 && rowOverhead !== 1'b1) @(negedge clk);
        pin = v;
    endtask
    // one request of n cycles, changed only on the falling edge
    task automatic pulse(input int n);
        @(negedge clk);
        edgeAtRot(1'b1);
        repeat (n) @(negedge clk);
        edgeAtRot(1'b0);
    endtask
endmodule
`default_nettype wire

//--- tb/exposure_readout_sequencer_sva.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module exposure_readout_sequencer_sva #(
    parameter int TIMER_W = exposure_readout_pkg::TIMER_W_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic triggeredShutter,
    input wire logic subsampleEnable,
    input wire logic cycleGranularity,
    input wire logic syncToRowOverhead,
    input wire logic reverseX,
    input wire logic [exposure_readout_pkg::WIN_W-1:0] windowCount,
    input wire logic [TIMER_W-1:0] rowOverheadCycles,
    input wire logic [TIMER_W-1:0] frameTransferCycles,
    input wire logic pixelReset,
    input wire logic integrating,
    input wire logic imageSample,
    input wire logic frameTransfer,
    input wire logic rowOverhead,
    input wire logic readoutBusy,
    input wire logic kernelValid,
    input wire logic [exposure_readout_pkg::KER_W-1:0] kernelAddress,
    input wire logic [exposure_readout_pkg::WIN_W-1:0] windowIndex
);
    // ****
    // phase length counters
    // ****
    logic [TIMER_W-1:0] fotCnt_q, rotCnt_q, fotLen, rotLen;
    logic [exposure_readout_pkg::KER_W-1:0] kStep;
    assign fotLen = (frameTransferCycles == '0) ? 16'h0001 : frameTransferCycles;
    assign rotLen = (rowOverheadCycles == '0) ? 16'h0001 : rowOverheadCycles;
    assign kStep = subsampleEnable ? 6'h02 : 6'h01;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) fotCnt_q <= '0;
        else fotCnt_q <= frameTransfer ? fotCnt_q + 16'h0001 : '0;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) rotCnt_q <= '0;
        else rotCnt_q <= rowOverhead ? rotCnt_q + 16'h0001 : '0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_RESET_NOT_INTEG: assert property (pixelReset != integrating)
        else $error("pixel reset and integration disagree");
    AST_SAMPLE_AFTER_INTEG: assert property ($fell(integrating) |-> imageSample)
        else $error("no image sample after integration end");
    AST_SAMPLE_OPENS_FOT: assert property (imageSample |-> frameTransfer && !integrating)
        else $error("image sample without frame transfer");
    AST_FOT_LENGTH: assert property ($fell(frameTransfer) |-> fotCnt_q == fotLen && rowOverhead)
        else $error("frame transfer length wrong");
    AST_ROT_LENGTH: assert property ($fell(rowOverhead) |-> rotCnt_q == rotLen)
        else $error("row overhead length wrong");
    AST_KERNEL_AFTER_ROT: assert property ($rose(kernelValid) |-> $past(rowOverhead, 2))
        else $error("kernels without row overhead");
    AST_KERNEL_STEP: assert property (kernelValid && $past(kernelValid) |->
        kernelAddress == (reverseX ? $past(kernelAddress) - kStep : $past(kernelAddress) + kStep))
        else $error("kernel address step wrong");
    AST_CHANGE_IN_ROT: assert property ($changed(integrating) && $past(readoutBusy) &&
        (!cycleGranularity || syncToRowOverhead) |-> $past(rowOverhead))
        else $error("integration changed outside row overhead");
    AST_WINDOW_ORDER: assert property ($changed(windowIndex) |->
        windowIndex == $past(windowIndex) + 2'h1 || windowIndex == 2'h0)
        else $error("window order wrong");
    AST_WINDOW_LIMIT: assert property (readoutBusy |-> windowIndex <= windowCount)
        else $error("window beyond count");
    AST_TRIG_HOLD_RESET: assert property (triggeredShutter && readoutBusy |-> pixelReset)
        else $error("array out of reset during readout");
    COV_TRIG: cover property (imageSample && triggeredShutter);
    COV_OVERLAP: cover property (integrating && readoutBusy);
    COV_FOUR: cover property (kernelValid && windowIndex == 2'h3);
endmodule
bind exposure_readout_sequencer exposure_readout_sequencer_sva #(.TIMER_W(TIMER_W)) checker_i (
    .clk(clk), .reset_n(reset_n), .triggeredShutter(triggeredShutter),
    .subsampleEnable(subsampleEnable), .cycleGranularity(cycleGranularity),
    .syncToRowOverhead(syncToRowOverhead), .reverseX(reverseX), .windowCount(windowCount),
    .rowOverheadCycles(rowOverheadCycles), .frameTransferCycles(frameTransferCycles),
    .pixelReset(pixelReset), .integrating(integrating), .imageSample(imageSample),
    .frameTransfer(frameTransfer), .rowOverhead(rowOverhead), .readoutBusy(readoutBusy),
    .kernelValid(kernelValid), .kernelAddress(kernelAddress), .windowIndex(windowIndex));
`default_nettype wire

//--- tb/exposure_readout_sequencer_test.sv
// self-checking bench for the exposure and readout sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module exposure_readout_sequencer_test;
    // ****
    // stimulus and monitors
    // ****
    logic clk, reset_n, captureEnable, masterTiming, triggeredShutter, subsampleEnable;
    logic cycleGranularity, syncToRowOverhead, reverseX, reverseY, integrationPinPrimary;
    logic pixelReset, integrating, imageSample, frameTransfer, rowOverhead, readoutBusy;
    logic kernelValid, ftPrev, overlapSeen;
    logic [3:0] cycleMultiplier;
    logic [1:0] windowCount, windowIndex;
    logic [15:0] resetLength, integrationTime, rowOverheadCycles, frameTransferCycles;
    logic [3:0][9:0] windowYStart, windowYEnd;
    logic [3:0][5:0] windowXStart, windowXKernels;
    logic [9:0] rowAddress, outputRow;
    logic [5:0] kernelAddress;
    logic [17:0] seen[$];
    int n_errors, samples_checked, cycles, imgCount, fotCount, len;
    int lens[4];
    exposure_readout_sequencer dut (.*);
    controller_model ctl (.clk(clk), .rowOverhead(rowOverhead), .readoutBusy(readoutBusy),
        .pin(integrationPinPrimary));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(negedge clk) begin
        if (imageSample === 1'b1) imgCount++;
        if (frameTransfer === 1'b1 && ftPrev !== 1'b1) fotCount++;
        if (kernelValid === 1'b1) seen.push_back({windowIndex, rowAddress, kernelAddress});
        if (integrating === 1'b1 && readoutBusy === 1'b1) overlapSeen = 1'b1;
        ftPrev = frameTransfer;
    end
    // the full run needs well under 20000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic doReset();
        captureEnable = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        captureEnable = 1'b1;
        imgCount = 0;
        fotCount = 0;
        seen.delete();
    endtask
    task automatic measure(output int n);
        for (int t = 0; integrating !== 1'b1 && t < 500; t++) @(negedge clk);
        for (n = 0; integrating === 1'b1 && n < 5000; n++) @(negedge clk);
    endtask
    task automatic waitIdle();
        repeat (2) @(negedge clk);
        for (int t = 0; readoutBusy !== 1'b0 && t < 2000; t++) @(negedge clk);
    endtask
    task automatic checkFrame(input int wc);
        logic [5:0] kx;
        logic [9:0] ry;
        int i;
        i = 0;
        `CHK("frame transfers", 1, fotCount)
        for (int w = 0; w <= wc; w++)
            for (int r = windowYStart[w]; r <= windowYEnd[w]; r++)
                for (int k = 0; k < windowXKernels[w]; k++) begin
                    kx = windowXStart[w] + 6'(subsampleEnable ? 2 * k : k);
                    ry = reverseY ? 10'h3FF - 10'(r) : 10'(r);
                    `CHK("kernel", {2'(w), ry, reverseX ? 6'h35 - kx : kx}, seen[i])
                    i++;
                end
        `CHK("kernel count", i, seen.size())
        `CHK("output rows", 10'(2 * (wc + 1)), outputRow)
    endtask
    initial begin
        {captureEnable, masterTiming, triggeredShutter, subsampleEnable} = 4'h0;
        {cycleGranularity, syncToRowOverhead, reverseX, reverseY} = 4'hC;
        {cycleMultiplier, windowCount} = 6'h00;
        resetLength = 16'h0002;
        integrationTime = 16'h0003;
        rowOverheadCycles = 16'h0004;
        frameTransferCycles = 16'h0003;
        for (int w = 0; w < 4; w++) begin
            windowYStart[w] = 10'(10 * w + 5);
            windowYEnd[w] = 10'(10 * w + 6);
            windowXStart[w] = 6'(4 * w + 1);
            windowXKernels[w] = 6'h03;
        end
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        ctl.pulse(3);
        repeat (8) @(negedge clk);
        `CHK("idle reset", 3'b100, {pixelReset, integrating, readoutBusy})
        for (int wc = 0; wc < 4; wc++) begin
            {triggeredShutter, masterTiming, syncToRowOverhead} = 3'h6;
            {windowCount, cycleMultiplier} = {2'(wc), 4'(wc)};
            {reverseX, reverseY, subsampleEnable} = {wc[0], wc[1], wc == 2};
            doReset();
            fork
                ctl.pulse(2);
                measure(lens[wc]);
            join
            fork
                ctl.pulse(2);
            join_none
            waitIdle();
            repeat (40) @(negedge clk);
            `CHK("images per request", 1, imgCount)
            if (wc > 0) `CHK("integration", 3 * ((1 << wc) - 1), lens[wc] - lens[0])
            checkFrame(wc);
        end
        for (int t = 0; t < 2; t++) begin
            {masterTiming, triggeredShutter} = {1'b0, t[0]};
            doReset();
            fork
                ctl.pulse(7);
                measure(len);
            join
            `CHK("slave integration", 7, len)
            waitIdle();
            `CHK("slave image", 1, imgCount)
        end
        for (int g = 1; g >= 0; g--) begin
            {masterTiming, triggeredShutter, cycleGranularity, syncToRowOverhead} = {2'h2, g[0], g[0]};
            resetLength = 16'h0002;
            integrationTime = g ? 16'h0028 : 16'h000A;
            doReset();
            overlapSeen = 1'b0;
            for (int t = 0; t < 8000 && imgCount < 3; t++) @(negedge clk);
            `CHK("continuous capture", 1'b1, imgCount >= 3)
            `CHK("integration during readout", 1'b1, overlapSeen)
        end
        wrap_up();
    end
endmodule
`default_nettype wire
